// File: vpaa_regs.v
`timescale 1ns/100ps
module vpaa_regs #(
	parameter [15:0] LPA_ABIL_VALUE = 16'h05e1
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_b,
	// Configuration straps, one per port
	input  wire        flow_control_manual_strap_p0,
	input  wire        flow_control_manual_strap_p1,
	// Host register port
	input  wire        host_rd,
	input  wire        host_wr,
	input  wire [8:0]  host_addr,
	input  wire [31:0] host_wdata,
	output reg  [31:0] host_rdata,
	output reg         host_ack,
	// MII management register port
	input  wire        mii_rd,
	input  wire        mii_wr,
	input  wire        mii_port,
	input  wire [4:0]  mii_idx,
	input  wire [15:0] mii_wdata,
	output reg  [15:0] mii_rdata,
	output reg         mii_ack
);
`include "vpaa_defs.vh"

	// Strap capture
	reg         strap_pend_reg;

	// Answer next values
	reg  [31:0] host_rdata_next;
	reg  [15:0] mii_rdata_next;
	reg         host_ack_next;
	reg         mii_ack_next;

	// Write path, one data bus per word
	reg         wr0;
	reg         wr1;
	reg  [15:0] wdat0;
	reg  [15:0] wdat1;

	// Stored and emulated words
	wire [15:0] adv0;
	wire [15:0] adv1;
	reg  [15:0] lpa_word;

	// Decodes
	wire        h_adv0;
	wire        h_adv1;
	wire        h_lpa0;
	wire        h_lpa1;
	wire        m_adv;
	wire        m_lpa;

	// Host offset match, shared by every mapped slot
	function vpaa_ofs_hit;
		input [8:0] addr;
		input [8:0] ofs;
		begin
			vpaa_ofs_hit = (addr == ofs);
		end
	endfunction

	// Management index match
	function vpaa_idx_hit;
		input [4:0] idx;
		input [4:0] want;
		begin
			vpaa_idx_hit = (idx == want);
		end
	endfunction

	// Low half of a host slot; upper half reserved
	function [31:0] vpaa_pad_word;
		input [15:0] word;
		begin
			vpaa_pad_word = {16'h0, word};
		end
	endfunction

	// One port's advertisement word
	function [15:0] vpaa_port_word;
		input        port_sel;
		input [15:0] word0;
		input [15:0] word1;
		begin
			if (port_sel) begin
				vpaa_port_word = word1;
			end else begin
				vpaa_port_word = word0;
			end
		end
	endfunction

	// Partner word is pure emulation, nothing stored
	always @* begin
		lpa_word                    = LPA_ABIL_VALUE;
		lpa_word[`VPAA_LPA_NP_BIT]  = 1'h0;
		lpa_word[`VPAA_LPA_ACK_BIT] = 1'h1;
	end

	assign h_adv0 = vpaa_ofs_hit(host_addr, `VPAA_P0_ADV_OFS);
	assign h_adv1 = vpaa_ofs_hit(host_addr, `VPAA_P1_ADV_OFS);
	assign h_lpa0 = vpaa_ofs_hit(host_addr, `VPAA_P0_LPA_OFS);
	assign h_lpa1 = vpaa_ofs_hit(host_addr, `VPAA_P1_LPA_OFS);
	assign m_adv  = vpaa_idx_hit(mii_idx, `VPAA_MII_ADV_IDX);
	assign m_lpa  = vpaa_idx_hit(mii_idx, `VPAA_MII_LPA_IDX);

	// Host wins a clash on one word; a write to the other word still lands
	always @* begin
		wr0   = 1'h0;
		wr1   = 1'h0;
		wdat0 = mii_wdata;
		wdat1 = mii_wdata;
		// Upper half of host data dropped: reserved
		if (host_wr & h_adv0) begin
			wr0   = 1'h1;
			wdat0 = host_wdata[15:0];
		end else if (mii_wr & m_adv & ~mii_port) begin
			wr0 = 1'h1;
		end
		if (host_wr & h_adv1) begin
			wr1   = 1'h1;
			wdat1 = host_wdata[15:0];
		end else if (mii_wr & m_adv & mii_port) begin
			wr1 = 1'h1;
		end
	end

	// Strap taken on the first clock after reset release
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			strap_pend_reg <= 1'b1;
		else
			strap_pend_reg <= 1'b0;
	end

	vpaa_adv_word u_adv0 (
		.ref_clk                   (ref_clk),
		.rst_b                     (rst_b),
		.strap_load                (strap_pend_reg),
		.flow_control_manual_strap (flow_control_manual_strap_p0),
		.wr_en                     (wr0),
		.wr_data                   (wdat0),
		.adv_word                  (adv0)
	);

	vpaa_adv_word u_adv1 (
		.ref_clk                   (ref_clk),
		.rst_b                     (rst_b),
		.strap_load                (strap_pend_reg),
		.flow_control_manual_strap (flow_control_manual_strap_p1),
		.wr_en                     (wr1),
		.wr_data                   (wdat1),
		.adv_word                  (adv1)
	);

	// Every request is answered, mapped or not
	always @* begin
		host_ack_next = host_rd | host_wr;
		mii_ack_next  = mii_rd | mii_wr;
	end

	// Host read data holds until the next read
	always @* begin
		host_rdata_next = host_rdata;
		if (host_rd) begin
			if (h_adv0) begin
				host_rdata_next = vpaa_pad_word(adv0);
			end else if (h_adv1) begin
				host_rdata_next = vpaa_pad_word(adv1);
			end else if (h_lpa0 | h_lpa1) begin
				host_rdata_next = vpaa_pad_word(lpa_word);
			end else begin
				// Unmapped offsets read zero
				host_rdata_next = 32'h0;
			end
		end
	end

	// Management read data, 16 bits wide
	always @* begin
		mii_rdata_next = mii_rdata;
		if (mii_rd) begin
			if (m_adv) begin
				mii_rdata_next = vpaa_port_word(mii_port, adv0,
					adv1);
			end else if (m_lpa) begin
				mii_rdata_next = lpa_word;
			end else begin
				mii_rdata_next = 16'h0;
			end
		end
	end

	// Registered answers, one cycle after the request
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			host_rdata <= 32'h0;
			host_ack   <= 1'h0;
			mii_rdata  <= 16'h0;
			mii_ack    <= 1'h0;
		end else begin
			host_ack   <= host_ack_next;
			mii_ack    <= mii_ack_next;
			host_rdata <= host_rdata_next;
			mii_rdata  <= mii_rdata_next;
		end
	end

endmodule // vpaa_regs

// File: vpaa_defs.vh
`ifndef VPAA_DEFS_VH
`define VPAA_DEFS_VH

// Host byte offsets
`define VPAA_P0_ADV_OFS      9'h1d0
`define VPAA_P0_LPA_OFS      9'h1d4
`define VPAA_P1_ADV_OFS      9'h0d0
`define VPAA_P1_LPA_OFS      9'h0d4

// Management register indices
`define VPAA_MII_ADV_IDX     5'h04
`define VPAA_MII_LPA_IDX     5'h05

// Advertisement field positions
`define VPAA_ADV_NP_BIT      15
`define VPAA_ADV_RF_BIT      13
`define VPAA_ADV_ASYM_BIT    11
`define VPAA_ADV_SYM_BIT     10
`define VPAA_ADV_T4_BIT      9
`define VPAA_ADV_ABIL_HI     8
`define VPAA_ADV_ABIL_LO     5
`define VPAA_ADV_SEL_HI      4
`define VPAA_ADV_SEL_LO      0

// Writable bits of the advertisement word
`define VPAA_ADV_WR_MASK     16'h0dff
// Reset values
`define VPAA_ABIL_RST        4'hf
`define VPAA_SEL_RST         5'h01

// Partner word field positions
`define VPAA_LPA_NP_BIT      15
`define VPAA_LPA_ACK_BIT     14

`endif

// File: vpaa_adv_word.v
`timescale 1ns/100ps
// One port's advertisement storage
module vpaa_adv_word (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_b,
	// Strap capture
	input  wire        strap_load,
	input  wire        flow_control_manual_strap,
	// Write
	input  wire        wr_en,
	input  wire [15:0] wr_data,
	// Read
	output wire [15:0] adv_word
);
`include "vpaa_defs.vh"

	reg [1:0] pause_reg;
	reg [3:0] abil_reg;
	reg [4:0] sel_reg;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pause_reg <= 2'h0;
			abil_reg  <= `VPAA_ABIL_RST;
			sel_reg   <= `VPAA_SEL_RST;
		end else if (strap_load) begin
			// Strap sampled just after release, not under reset
			pause_reg <= {2{~flow_control_manual_strap}};
		end else if (wr_en) begin
			pause_reg <= wr_data[`VPAA_ADV_ASYM_BIT:`VPAA_ADV_SYM_BIT];
			abil_reg  <= wr_data[`VPAA_ADV_ABIL_HI:`VPAA_ADV_ABIL_LO];
			// Software must only write the 802.3 code here
			sel_reg   <= wr_data[`VPAA_ADV_SEL_HI:`VPAA_ADV_SEL_LO];
		end
	end

	// Fixed zeros at 15,14,13,12,9; writes there never land
	assign adv_word = {3'h0, 1'h0, pause_reg, 1'h0, abil_reg,
		sel_reg};

endmodule // vpaa_adv_word

// File: vpaa_regs_assertions.sv
`timescale 1ns/100ps
module vpaa_regs_checker (
	// Clock and reset
	input wire        ref_clk,
	input wire        rst_b,
	// Host port
	input wire        host_rd,
	input wire        host_wr,
	input wire        host_ack,
	input wire [31:0] host_rdata,
	// Management port
	input wire        mii_rd,
	input wire        mii_wr,
	input wire        mii_ack,
	input wire [4:0]  mii_idx,
	input wire [15:0] mii_rdata
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_adv;
		mii_rd && mii_idx == 5'h04;
	endsequence
	sequence s_lpa;
		mii_rd && mii_idx == 5'h05;
	endsequence
	a_host_ack_next: assert property (
		(host_rd || host_wr) |=> host_ack)
		else $error("host ack missing");
	a_mii_ack_next: assert property (
		(mii_rd || mii_wr) |=> mii_ack)
		else $error("mii ack missing");
	a_upper_half_zero: assert property (
		host_ack |-> !(|host_rdata[31:16]))
		else $error("upper half set");
	a_adv_np_zero: assert property (
		s_adv |=> !mii_rdata[15])
		else $error("next page set");
	a_adv_rf_zero: assert property (
		s_adv |=> !mii_rdata[13])
		else $error("remote fault set");
	a_adv_t4_zero: assert property (
		s_adv |=> !mii_rdata[9])
		else $error("t4 bit set");
	a_resvd_bits_zero: assert property (
		s_adv |=> !mii_rdata[14] && !mii_rdata[12])
		else $error("reserved bit set");
	a_lpa_fixed_bits: assert property (
		s_lpa |=> mii_rdata[15:14] == 2'h1)
		else $error("partner fixed bits wrong");
endmodule // vpaa_regs_checker
bind vpaa_regs vpaa_regs_checker u_chk (.*);

// File: vpaa_mgmt_host.sv
`timescale 1ns/100ps
module vpaa_mgmt_host (
	// Clock
	input  wire        ref_clk,
	// Answers from the block
	input  wire        mii_ack,
	input  wire [15:0] mii_rdata,
	// Requests to the block
	output reg         mii_rd = 1'h0,
	output reg         mii_wr = 1'h0,
	output reg         mii_port = 1'h0,
	output reg  [4:0]  mii_idx = 5'h0,
	output reg  [15:0] mii_wdata = 16'h0
);
	task op(
		input         w,
		input         p,
		input  [4:0]  i,
		input  [15:0] d,
		output [15:0] q,
		output        a
	);
		@(posedge ref_clk);
		mii_rd <= !w;
		mii_wr <= w;
		mii_port <= p;
		mii_idx <= i;
		mii_wdata <= w ? {d[15:5], 5'h01} : d;
		@(posedge ref_clk);
		mii_rd <= 1'h0;
		mii_wr <= 1'h0;
		// Released data flips so a stale value cannot pass
		mii_wdata <= ~mii_wdata;
		@(posedge ref_clk);
		q = mii_rdata;
		a = mii_ack;
	endtask
endmodule // vpaa_mgmt_host

// File: virtual_phy_autoneg_advert_bench.sv
`timescale 1ns/100ps
module virtual_phy_autoneg_advert_bench;
	reg         ref_clk = 1'h0, rst_b = 1'h0, host_rd = 1'h0, host_wr = 1'h0;
	reg         flow_control_manual_strap_p0 = 1'h0;
	reg         flow_control_manual_strap_p1 = 1'h1;
	reg  [8:0]  host_addr = 9'h0;
	reg  [31:0] host_wdata = 32'h0;
	wire [31:0] host_rdata;
	wire        host_ack, mii_rd, mii_wr, mii_port, mii_ack;
	wire [4:0]  mii_idx;
	wire [15:0] mii_wdata, mii_rdata;
	reg  [15:0] q;
	reg         a;
	integer     fail_count = 0, check_count = 0;
	// All-ones partner word shows the forced bits
	vpaa_regs #(.LPA_ABIL_VALUE(16'hffff)) dut (.*);
	vpaa_mgmt_host host (.*);
	initial forever #12.5 ref_clk = ~ref_clk;
	task finish_test;
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input [95:0] n, input [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0s exp %h got %h", n, e, g);
		end
	endtask
	task hx(input w, input [8:0] ad, input [31:0] d, e);
		@(posedge ref_clk);
		host_rd <= !w;
		host_wr <= w;
		host_addr <= ad;
		host_wdata <= d;
		@(posedge ref_clk);
		host_rd <= 1'h0;
		host_wr <= 1'h0;
		host_wdata <= ~d;
		@(posedge ref_clk);
		chk("host_ack", 32'h1, {31'h0, host_ack});
		if (!w) chk("host_rdata", e, host_rdata);
	endtask
	task mx(input w, p, input [4:0] i, input [15:0] d, e);
		host.op(w, p, i, d, q, a);
		chk("mii_ack", 32'h1, {31'h0, a});
		if (!w) chk("mii_rdata", {16'h0, e}, {16'h0, q});
	endtask
	task t_reset_values;
		hx(1'h0, 9'h1d0, 32'h0, 32'h0000_0de1);
		hx(1'h0, 9'h0d0, 32'h0, 32'h0000_01e1);
		hx(1'h0, 9'h1d4, 32'h0, 32'h0000_7fff);
	endtask
	task t_host_write;
		hx(1'h1, 9'h0d0, 32'hffff_ffe1, 32'h0);
		hx(1'h0, 9'h0d0, 32'h0, 32'h0000_0de1);
		hx(1'h1, 9'h1d0, 32'hffff_f221, 32'h0);
		hx(1'h0, 9'h1d0, 32'h0, 32'h0000_0021);
		hx(1'h1, 9'h1d4, 32'h0, 32'h0);
		hx(1'h0, 9'h1d4, 32'h0, 32'h0000_7fff);
		hx(1'h0, 9'h100, 32'h0, 32'h0);
	endtask
	task t_mii;
		mx(1'h0, 1'h0, 5'h04, 16'h0, 16'h0021);
		mx(1'h0, 1'h1, 5'h04, 16'h0, 16'h0de1);
		mx(1'h1, 1'h1, 5'h04, 16'h0, 16'h0);
		mx(1'h0, 1'h1, 5'h04, 16'h0, 16'h0001);
		mx(1'h0, 1'h0, 5'h05, 16'h0, 16'h7fff);
		mx(1'h0, 1'h0, 5'h07, 16'h0, 16'h0);
	endtask
	// Same-cycle writes: host wins one word, other word still lands
	task t_clash;
		fork
			hx(1'h1, 9'h1d0, 32'h0000_0c61, 32'h0);
			mx(1'h1, 1'h0, 5'h04, 16'h0181, 16'h0);
		join
		hx(1'h0, 9'h1d0, 32'h0, 32'h0000_0c61);
		fork
			hx(1'h1, 9'h1d0, 32'h0000_0de1, 32'h0);
			mx(1'h1, 1'h1, 5'h04, 16'h0c21, 16'h0);
		join
		mx(1'h0, 1'h0, 5'h04, 16'h0, 16'h0de1);
		mx(1'h0, 1'h1, 5'h04, 16'h0, 16'h0c21);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge ref_clk);
		t_reset_values;
		t_host_write;
		t_mii;
		t_clash;
		finish_test;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		fail_count++;
		finish_test;
	end
endmodule // virtual_phy_autoneg_advert_bench
